// ==== shared/aiseq_pkg.sv ====
package aiseq_pkg;
  // Sample count and channel widths
  localparam int CNT_W = 32;
  localparam int NCH = 8;
  localparam int SMP_W = 16;
  // FIFO geometry, log2 of depth
  localparam int FIFO_AW = 4;
  localparam int FIFO_DEPTH = 16;
  // Block size that triggers a transfer request, in words
  localparam logic [FIFO_AW:0] DMA_BLOCK = 5'h04;
  // Counter constants
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;
  localparam logic [FIFO_AW:0] LVL_ONE = 5'h01;
  localparam logic [FIFO_AW-1:0] PTR_ONE = 4'h1;

  // Acquisition state
  typedef enum logic [2:0] {
    AISEQ_IDLE = 3'b000,
    AISEQ_WAIT_START = 3'b001,
    AISEQ_RUN = 3'b010,
    AISEQ_POST = 3'b011,
    AISEQ_DONE = 3'b100
  } aiseq_state_e;

  // Host control and configuration
  typedef struct packed {
    logic arm;
    logic stop;
    logic sw_convert;
    logic hw_timed;
    logic ext_clk_sel;
    logic continuous;
    logic single_point;
    logic paired;
    logic start_trig_en;
    logic ref_trig_en;
    logic hold_trig_en;
    logic hold_active_high;
    logic ovf_clear;
    logic late_clear;
    logic point_read;
    logic [CNT_W-1:0] sample_total;
    logic [CNT_W-1:0] post_total;
  } aiseq_ctrl_s;

  // Status back to the host
  typedef struct packed {
    logic running;
    logic done;
    logic overflow;
    logic late;
    logic [CNT_W-1:0] acquired;
  } aiseq_stat_s;

  // One simultaneous sample word across channels
  typedef logic [NCH*SMP_W-1:0] aiseq_word_t;
endpackage

// ==== hdl/aiseq_top.sv ====
`timescale 1ns/1ps
// What this block does
// R1: One conversion per software command
// R2: Hardware pacing from internal or external clock
// R3: Finite mode stops after programmed count
// R4: Host uses finite mode with reference trigger
// R5: Continuous mode runs until host stops
// R6: Samples leave FIFO in DMA blocks
// R7: Full FIFO overwrites oldest, flags overflow
// R8: Paired transfer drops final odd sample
// R9: Host pads odd totals with extra channel
// R10: Flag single-point software missed clock period
// R11: Start, reference and pause trigger actions
// R12: Pause holds pacing while level active; the code holds only hardware pacing, software commands still convert
// R13: Each pacing edge converts all channels
// R14: Overflow sticky until cleared or stopped
module aiseq_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Host control
  input wire aiseq_pkg::aiseq_ctrl_s ctrl,
  // Pins from outside the clock domain
  input wire logic ext_clk_pin,
  input wire logic start_trig_pin,
  input wire logic ref_trig_pin,
  input wire logic hold_trig_pin,
  // Internal pacing tick from the timing engine
  input wire logic int_clk_tick,
  // Converter interface
  input wire aiseq_pkg::aiseq_word_t adc_data,
  output logic adc_convert,
  // DMA side
  input wire logic dma_ready,
  output logic dma_req,
  output logic dma_valid,
  output aiseq_pkg::aiseq_word_t dma_data_lo,
  output aiseq_pkg::aiseq_word_t dma_data_hi,
  // Status
  output aiseq_pkg::aiseq_stat_s status
);
  // Three-stage synchronisers for pins: [0] first, [1],[2] compared
  logic [2:0] ext_clk_sq, start_sq, ref_sq, hold_sq;
  // Filtered levels after second and third agree
  logic ext_clk_f_q, start_f_q, ref_f_q, hold_f_q;
  logic ext_clk_prev_q, start_prev_q, ref_prev_q;
  aiseq_pkg::aiseq_state_e state_q;
  logic [aiseq_pkg::CNT_W-1:0] count_q;
  logic [aiseq_pkg::CNT_W-1:0] post_q;
  // Sample FIFO storage
  aiseq_pkg::aiseq_word_t mem [aiseq_pkg::FIFO_DEPTH];
  logic [aiseq_pkg::FIFO_AW-1:0] wr_q, rd_q;
  logic [aiseq_pkg::FIFO_AW:0] lvl_q;
  logic overflow_q, late_q, unread_q;
  logic pace_tick, push, full, pop_n, pop_pair, pop_one, can_pop;
  logic ext_rise, start_rise, ref_rise, hold_on, active;

  // Synchronise pins through three flip-flops
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_clk_sq <= 3'h0;
      start_sq <= 3'h0;
      ref_sq <= 3'h0;
      hold_sq <= 3'h0;
    end else begin
      ext_clk_sq <= {ext_clk_sq[1:0], ext_clk_pin};
      start_sq <= {start_sq[1:0], start_trig_pin};
      ref_sq <= {ref_sq[1:0], ref_trig_pin};
      hold_sq <= {hold_sq[1:0], hold_trig_pin};
    end
  end

  // Accept a level change only when stages two and three agree
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_clk_f_q <= 1'b0;
      start_f_q <= 1'b0;
      ref_f_q <= 1'b0;
      hold_f_q <= 1'b0;
      ext_clk_prev_q <= 1'b0;
      start_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      if (ext_clk_sq[1] == ext_clk_sq[2]) ext_clk_f_q <= ext_clk_sq[2];
      if (start_sq[1] == start_sq[2]) start_f_q <= start_sq[2];
      if (ref_sq[1] == ref_sq[2]) ref_f_q <= ref_sq[2];
      if (hold_sq[1] == hold_sq[2]) hold_f_q <= hold_sq[2];
      ext_clk_prev_q <= ext_clk_f_q;
      start_prev_q <= start_f_q;
      ref_prev_q <= ref_f_q;
    end
  end

  // Edge and level terms of the filtered pins
  assign ext_rise = ext_clk_f_q & ~ext_clk_prev_q;
  assign start_rise = start_f_q & ~start_prev_q;
  assign ref_rise = ref_f_q & ~ref_prev_q;
  // Pause trigger is level sensitive, polarity programmable [R12]
  assign hold_on = ctrl.hold_trig_en & (hold_f_q == ctrl.hold_active_high); // [R12]
  assign active = (state_q == aiseq_pkg::AISEQ_RUN) || (state_q == aiseq_pkg::AISEQ_POST);

  // Pacing: one software command or one pacing-clock edge each [R1] [R2]
  always_comb begin
    if (ctrl.hw_timed) begin
      pace_tick = (ctrl.ext_clk_sel ? ext_rise : int_clk_tick) & ~hold_on; // [R2] [R12]
    end else begin
      pace_tick = ctrl.sw_convert; // [R1]
    end
  end
  assign push = active & pace_tick;

  // Acquisition sequencer with start and reference actions [R11]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= aiseq_pkg::AISEQ_IDLE;
      count_q <= aiseq_pkg::CNT_ZERO;
      post_q <= aiseq_pkg::CNT_ZERO;
    end else if (ctrl.stop) begin
      // Host stop ends any mode, continuous included [R5]
      state_q <= aiseq_pkg::AISEQ_IDLE;
    end else begin
      case (state_q)
        aiseq_pkg::AISEQ_IDLE: begin
          if (ctrl.arm) begin
            count_q <= aiseq_pkg::CNT_ZERO;
            post_q <= aiseq_pkg::CNT_ZERO;
            state_q <= ctrl.start_trig_en ? aiseq_pkg::AISEQ_WAIT_START
                                          : aiseq_pkg::AISEQ_RUN; // [R11]
          end
        end
        aiseq_pkg::AISEQ_WAIT_START: begin
          if (start_rise) state_q <= aiseq_pkg::AISEQ_RUN; // [R11]
        end
        aiseq_pkg::AISEQ_RUN: begin
          if (push) count_q <= count_q + aiseq_pkg::CNT_ONE;
          // Reference trigger assumes finite mode chosen by host [R4]
          if (ctrl.ref_trig_en && ref_rise) begin
            state_q <= aiseq_pkg::AISEQ_POST; // [R11]
          end else if (!ctrl.continuous && !ctrl.ref_trig_en && push &&
                       (count_q + aiseq_pkg::CNT_ONE >= ctrl.sample_total)) begin
            state_q <= aiseq_pkg::AISEQ_DONE; // [R3]
          end
        end
        aiseq_pkg::AISEQ_POST: begin
          if (push) begin
            count_q <= count_q + aiseq_pkg::CNT_ONE;
            post_q <= post_q + aiseq_pkg::CNT_ONE;
            if (post_q + aiseq_pkg::CNT_ONE >= ctrl.post_total) begin
              state_q <= aiseq_pkg::AISEQ_DONE; // [R3]
            end
          end
        end
        aiseq_pkg::AISEQ_DONE: begin
          if (ctrl.arm) state_q <= aiseq_pkg::AISEQ_IDLE;
        end
        default: state_q <= aiseq_pkg::AISEQ_IDLE;
      endcase
    end
  end

  // One convert strobe drives every channel converter at once [R13]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) adc_convert <= 1'b0;
    else adc_convert <= push; // [R13]
  end

  // FIFO pop rules: pairs only when paired, so a lone last word stays [R8]
  assign full = (lvl_q == aiseq_pkg::FIFO_DEPTH[aiseq_pkg::FIFO_AW:0]);
  assign can_pop = ctrl.single_point ? 1'b0 :
                   (ctrl.paired ? (lvl_q > aiseq_pkg::LVL_ONE) : (lvl_q != '0)); // [R8]
  assign pop_n = can_pop & dma_ready & ~dma_valid;
  assign pop_pair = pop_n & ctrl.paired;
  assign pop_one = pop_n & ~ctrl.paired;

  // FIFO with overwrite of oldest data when full [R7]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      lvl_q <= '0;
    end else begin
      logic [aiseq_pkg::FIFO_AW-1:0] rd_n;
      logic [aiseq_pkg::FIFO_AW:0] lvl_n;
      rd_n = rd_q;
      lvl_n = lvl_q;
      if (pop_pair) begin
        rd_n = rd_n + aiseq_pkg::PTR_ONE + aiseq_pkg::PTR_ONE;
        lvl_n = lvl_n - aiseq_pkg::LVL_ONE - aiseq_pkg::LVL_ONE;
      end else if (pop_one) begin
        rd_n = rd_n + aiseq_pkg::PTR_ONE;
        lvl_n = lvl_n - aiseq_pkg::LVL_ONE;
      end
      if (push) begin
        mem[wr_q] <= adc_data;
        wr_q <= wr_q + aiseq_pkg::PTR_ONE;
        if (full && !pop_n) rd_n = rd_n + aiseq_pkg::PTR_ONE; // [R7]
        else lvl_n = lvl_n + aiseq_pkg::LVL_ONE;
      end
      rd_q <= rd_n;
      lvl_q <= lvl_n;
    end
  end

  // Block transfer request and data beats toward host memory [R6]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_req <= 1'b0;
      dma_valid <= 1'b0;
      dma_data_lo <= '0;
      dma_data_hi <= '0;
    end else begin
      dma_req <= !ctrl.single_point &&
                 ((lvl_q >= aiseq_pkg::DMA_BLOCK) || (state_q == aiseq_pkg::AISEQ_DONE
                  && can_pop)); // [R6]
      dma_valid <= pop_n;
      if (pop_n) begin
        dma_data_lo <= mem[rd_q];
        dma_data_hi <= ctrl.paired ? mem[rd_q + aiseq_pkg::PTR_ONE] : '0; // [R8]
      end
    end
  end

  // Sticky overflow; new event wins over host clear or stop [R7] [R14]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) overflow_q <= 1'b0;
    else if (push && full && !pop_n) overflow_q <= 1'b1; // [R7]
    else if (ctrl.ovf_clear || ctrl.stop) overflow_q <= 1'b0; // [R14]
  end

  // Single-point lateness: new tick before software read of last [R10]
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      unread_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      if (push && ctrl.single_point) unread_q <= 1'b1;
      else if (ctrl.point_read) unread_q <= 1'b0;
      if (push && ctrl.single_point && unread_q && !ctrl.point_read) late_q <= 1'b1; // [R10]
      else if (ctrl.late_clear || ctrl.stop) late_q <= 1'b0;
    end
  end

  // Registered status outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) status <= '0;
    else begin
      status.running <= active || (state_q == aiseq_pkg::AISEQ_WAIT_START);
      status.done <= (state_q == aiseq_pkg::AISEQ_DONE);
      status.overflow <= overflow_q;
      status.late <= late_q;
      status.acquired <= count_q;
    end
  end
endmodule

// ==== test/aiseq_checker.sv ====
`timescale 1ns/1ps
module aiseq_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Watched ports
  input wire aiseq_pkg::aiseq_ctrl_s ctrl,
  input wire logic hold_trig_pin,
  input wire logic adc_convert,
  input wire logic dma_ready,
  input wire logic dma_valid,
  input wire aiseq_pkg::aiseq_stat_s status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // A command while running converts on the next cycle
  property p_sw_conv;
    ctrl.sw_convert && !ctrl.hw_timed && ctrl.continuous && !ctrl.hold_trig_en && status.running
      && !ctrl.stop && !$past(ctrl.stop) |=> adc_convert;
  endproperty
  a_sw_conv: assert property (p_sw_conv)
    else $error("command without conversion");
  // Conversions only while running
  property p_conv_run;
    adc_convert |-> status.running;
  endproperty
  a_conv_run: assert property (p_conv_run)
    else $error("conversion outside a run");
  // Each conversion adds exactly one sample
  // The count is registered behind the strobe, so it settles one cycle after it
  property p_acq_inc;
    adc_convert && $past(status.running) |=>
      status.acquired == $past(status.acquired) + aiseq_pkg::CNT_ONE;
  endproperty
  a_acq_inc: assert property (p_acq_inc)
    else $error("sample count step wrong");
  // Finite run never passes its total
  property p_fin_cap;
    status.running && !ctrl.continuous && !ctrl.ref_trig_en |->
      status.acquired <= ctrl.sample_total;
  endproperty
  a_fin_cap: assert property (p_fin_cap)
    else $error("finite run overran");
  // Overflow falls only after a clear or stop
  property p_ovf_stick;
    $fell(status.overflow) |-> $past(ctrl.ovf_clear) || $past(ctrl.ovf_clear, 2)
      || $past(ctrl.stop) || $past(ctrl.stop, 2);
  endproperty
  a_ovf_stick: assert property (p_ovf_stick)
    else $error("overflow lost");
  // A beat follows an accepted ready
  property p_beat_src;
    dma_valid |-> $past(dma_ready);
  endproperty
  a_beat_src: assert property (p_beat_src)
    else $error("beat without ready");
  // Beats never back to back
  property p_beat_gap;
    dma_valid |=> !dma_valid;
  endproperty
  a_beat_gap: assert property (p_beat_gap)
    else $error("beats too close");
  // A held pacing clock gives no conversion
  property p_hold;
    (ctrl.hold_trig_en && ctrl.hw_timed && hold_trig_pin == ctrl.hold_active_high) [*8]
      |-> !adc_convert;
  endproperty
  a_hold: assert property (p_hold)
    else $error("conversion while held");
  c_ovf: cover property ($rose(status.overflow));
  c_done: cover property ($rose(status.done));
  c_pair: cover property (dma_valid && ctrl.paired);
endmodule

// ==== test/aiseq_dma_host.sv ====
`timescale 1ns/1ps
module aiseq_dma_host (
  // Clock and answer pace: 0 prompt, 1 random stalls, 2 stalled
  input wire logic mclk,
  input wire logic [1:0] slow,
  input wire logic pr,
  // Transfer side
  input wire logic dma_req,
  input wire logic dma_valid,
  input wire aiseq_pkg::aiseq_word_t dma_data_lo,
  input wire aiseq_pkg::aiseq_word_t dma_data_hi,
  output logic dma_ready = 1'b0
);
  // Words taken, oldest first
  aiseq_pkg::aiseq_word_t got[$];
  int seed = 32'hebc37dfe;
  // Ready answers the request, maybe late
  always @(negedge mclk) begin
    dma_ready <= dma_req && (slow == 0 || (slow == 1 && ($random(seed) & 1)));
  end
  // Keep each beat, both words when paired
  always @(posedge mclk) begin
    if (dma_valid === 1'b1) begin
      got.push_back(dma_data_lo);
      if (pr) got.push_back(dma_data_hi);
    end
  end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  // Stimulus; reference trigger pulses only in the final test
  logic mclk = 0, sys_rst = 1, ext_clk_pin = 0, int_clk_tick = 0, hold_trig_pin = 0;
  logic start_trig_pin = 0, ref_trig_pin = 0;
  logic [1:0] slow = 0;
  aiseq_pkg::aiseq_ctrl_s c = '0;
  aiseq_pkg::aiseq_word_t adc_data = '0, lo, hi;
  logic adc_convert, dma_req, dma_valid, dma_ready;
  aiseq_pkg::aiseq_stat_s status;
  // Model of accepted words and counters
  aiseq_pkg::aiseq_word_t exp_q[$];
  int err_count = 0, checks_done = 0, nconv = 0, seed = 32'hebc37dfe;
  always #20 mclk = ~mclk;
  aiseq_top u_aiseq_top (.mclk, .sys_rst, .ctrl(c), .ext_clk_pin, .start_trig_pin,
    .ref_trig_pin, .hold_trig_pin, .int_clk_tick, .adc_data, .adc_convert, .dma_ready,
    .dma_req, .dma_valid, .dma_data_lo(lo), .dma_data_hi(hi), .status);
  aiseq_dma_host u_aiseq_dma_host (.mclk, .slow, .pr(c.paired), .dma_req, .dma_valid,
    .dma_data_lo(lo), .dma_data_hi(hi), .dma_ready);
  // Count conversions
  always @(posedge mclk) if (adc_convert === 1'b1) nconv++;
  // Verdict and end of run
  task conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compare one value
  task chk(input logic [127:0] g, e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One-cycle host strobes
  task strobe(input bit a, s, o);
    @(negedge mclk);
    c.arm = a;
    c.stop = s;
    c.ovf_clear = o;
    @(negedge mclk);
    c.arm = 0;
    c.stop = 0;
    c.ovf_clear = 0;
  endtask
  // One pace from the selected source; keep marks an accepted one
  task pace(input bit keep);
    @(negedge mclk);
    adc_data = {4{$random(seed)}};
    if (keep) exp_q.push_back(adc_data);
    if (!c.hw_timed) c.sw_convert = 1;
    else if (c.ext_clk_sel) ext_clk_pin = 1;
    else int_clk_tick = 1;
    @(negedge mclk);
    c.sw_convert = 0;
    int_clk_tick = 0;
    repeat (3) @(negedge mclk);
    ext_clk_pin = 0;
    repeat (4) @(negedge mclk);
  endtask
  // Arm, pace hn times held then n times, compare with the model
  task run(input bit hw, ext, cont, pr, input int tot, n, hn);
    int acc, ws, j, base, pend;
    repeat (4) @(negedge mclk);
    // Words still in the FIFO stay in the model and reach the host later
    u_aiseq_dma_host.got.delete();
    base = exp_q.size();
    c.hw_timed = hw;
    c.ext_clk_sel = ext;
    c.continuous = cont;
    c.paired = pr;
    c.hold_trig_en = hn > 0;
    c.hold_active_high = 1;
    c.sample_total = tot;
    if (status.done === 1'b1) strobe(1, 0, 0);
    strobe(1, 0, 0);
    nconv = 0;
    hold_trig_pin = hn > 0;
    repeat (8) @(negedge mclk);
    for (j = 0; j < hn; j++) pace(0);
    hold_trig_pin = 0;
    repeat (8) @(negedge mclk);
    for (j = 0; j < n; j++) pace(cont || j < tot);
    repeat (30) @(negedge mclk);
    acc = exp_q.size() - base;
    pend = exp_q.size();
    // Stalled host takes nothing; a running unpaired stream keeps one block less one
    if (slow == 2) ws = 0;
    else if (cont) ws = pend >= int'(aiseq_pkg::DMA_BLOCK) ?
                        pend - int'(aiseq_pkg::DMA_BLOCK) + 1 : 0;
    else ws = pr ? pend & ~1 : pend;
    chk(nconv, acc);
    chk(status.acquired, acc);
    chk(status.done, !cont);
    chk(status.running, cont);
    chk(u_aiseq_dma_host.got.size(), ws);
    for (j = 0; j < ws; j++) chk(u_aiseq_dma_host.got[j], exp_q.pop_front());
  endtask
  // Cut a hang short
  initial begin
    #3000000;
    err_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (12) @(negedge mclk);
    sys_rst = 0;
    run(0, 0, 0, 1, 8, 10, 0);
    slow = 1;
    run(0, 0, 0, 1, 5, 5, 0);
    run(1, 0, 1, 0, 0, 8, 3);
    strobe(0, 1, 0);
    run(1, 1, 0, 0, 4, 4, 0);
    slow = 2;
    run(0, 0, 1, 0, 0, 20, 0);
    chk(status.overflow, 1);
    repeat (20) @(negedge mclk);
    chk(status.overflow, 1);
    strobe(0, 0, 1);
    repeat (4) @(negedge mclk);
    chk(status.overflow, 0);
    // Single point behind a start trigger: lateness flag and its clear
    strobe(0, 1, 0);
    c.hw_timed = 1;
    c.ext_clk_sel = 0;
    c.single_point = 1;
    c.start_trig_en = 1;
    strobe(1, 0, 0);
    nconv = 0;
    pace(0);
    chk(nconv, 0);
    start_trig_pin = 1;
    repeat (4) @(negedge mclk);
    start_trig_pin = 0;
    repeat (8) @(negedge mclk);
    pace(0);
    c.point_read = 1;
    @(negedge mclk);
    c.point_read = 0;
    pace(0);
    chk(status.late, 0);
    pace(0);
    chk(status.late, 1);
    c.late_clear = 1;
    @(negedge mclk);
    c.late_clear = 0;
    repeat (2) @(negedge mclk);
    chk(status.late, 0);
    chk(nconv, 3);
    // Reference trigger in finite mode: three before the edge, two after
    strobe(0, 1, 0);
    c.single_point = 0;
    c.hw_timed = 0;
    c.continuous = 0;
    c.start_trig_en = 0;
    c.ref_trig_en = 1;
    c.post_total = 2;
    strobe(1, 0, 0);
    nconv = 0;
    repeat (3) pace(0);
    ref_trig_pin = 1;
    repeat (4) @(negedge mclk);
    ref_trig_pin = 0;
    repeat (8) @(negedge mclk);
    repeat (3) pace(0);
    chk(nconv, 5);
    chk(status.done, 1);
    conclude();
  end
endmodule
bind aiseq_top aiseq_checker u_aiseq_checker (.mclk, .sys_rst, .ctrl, .hold_trig_pin,
  .adc_convert, .dma_ready, .dma_valid, .status);
